/* verilog/adc_sequencer_control.sv */
// successive-approximation conversion sequencer with AXI4-Lite registers
`timescale 1ns/10ps
module adc_sequencer_control (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic [adc_seq_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [adc_seq_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic haltMode,
	input wire logic compareHigh,
	output logic converterPower,
	output logic [2:0] inputSelect,
	output logic gainStageSelect,
	output logic sampleEnable,
	output logic holdActive,
	output logic [7:0] sarCode
);
	import adc_seq_pkg::*;

	// --------------------------------------------------------------
	// declarations
	// --------------------------------------------------------------
	logic awHeld;
	logic wHeld;
	logic [ADDR_W-1:0] awAddrQ;
	logic [7:0] wDataQ;
	logic wLaneQ;
	logic doWrite;
	logic writeMapped;
	logic controlWrite;
	logic ampWrite;
	logic readTake;
	logic resultRead;
	logic [7:0] readByte;
	logic readMapped;

	logic convSpeed;
	logic powerOn;
	logic [2:0] channel;
	logic convSlow;
	logic gainSel;
	logic doneFlag;
	logic [7:0] result;

	logic [1:0] divCount;
	logic stepEnable;

	logic compMeta;
	logic compSync;

	seq_state_t state;
	logic [$clog2(STAB_CYCLES+1)-1:0] stabCount;
	logic [$clog2(SAMPLE_STEPS+1)-1:0] sampleCount;
	logic [1:0] settleCount;
	logic [7:0] bitMask;
	logic [7:0] decided;
	logic decideNow;
	logic convDone;
	logic restartOn;

	// --------------------------------------------------------------
	// write channel: address and data taken in either order
	// --------------------------------------------------------------
	// one write at a time: both readies stay low until the answer is taken
	assign s_axi_awready = !awHeld && !s_axi_bvalid;
	assign s_axi_wready = !wHeld && !s_axi_bvalid;
	assign doWrite = awHeld && wHeld;

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			awHeld <= 1'b0;
			awAddrQ <= '0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			awHeld <= 1'b1;
			awAddrQ <= s_axi_awaddr;
		end else if (doWrite) begin
			awHeld <= 1'b0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			wHeld <= 1'b0;
			wDataQ <= RESET_BYTE;
			wLaneQ <= 1'b0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			wHeld <= 1'b1;
			wDataQ <= s_axi_wdata[7:0];
			wLaneQ <= s_axi_wstrb[0];
		end else if (doWrite) begin
			wHeld <= 1'b0;
		end
	end

	assign writeMapped = (awAddrQ == ADDR_CONTROL) || (awAddrQ == ADDR_RESULT)
		|| (awAddrQ == ADDR_AMPLIFIER);
	// a write without byte lane 0 stores nothing and does not restart
	assign controlWrite = doWrite && wLaneQ && (awAddrQ == ADDR_CONTROL);
	assign ampWrite = doWrite && wLaneQ && (awAddrQ == ADDR_AMPLIFIER);

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else if (doWrite) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= writeMapped ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// --------------------------------------------------------------
	// read channel
	// --------------------------------------------------------------
	// reads insert no wait state: data is registered at the address edge
	assign s_axi_arready = !s_axi_rvalid;
	assign readTake = s_axi_arvalid && s_axi_arready;
	assign resultRead = readTake && (s_axi_araddr == ADDR_RESULT);

	always_comb begin
		readByte = RESET_BYTE;
		readMapped = 1'b1;
		unique case (s_axi_araddr)
			ADDR_CONTROL: begin
				readByte[DONE_BIT] = doneFlag;
				readByte[SPEED_BIT] = convSpeed;
				readByte[POWER_BIT] = powerOn;
				readByte[CHANNEL_MSB:0] = channel;
			end
			ADDR_RESULT: begin
				readByte = result;
			end
			ADDR_AMPLIFIER: begin
				readByte[SLOW_BIT] = convSlow;
				readByte[GAIN_BIT] = gainSel;
			end
			default: begin
				readMapped = 1'b0;
			end
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= RESP_OKAY;
		end else if (readTake) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= {24'h000000, readByte};
			s_axi_rresp <= readMapped ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// --------------------------------------------------------------
	// software registers
	// --------------------------------------------------------------
	// reserved control bits 4:3 are simply not stored
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			convSpeed <= 1'b0;
			powerOn <= 1'b0;
			channel <= RESET_CHANNEL;
		end else if (controlWrite) begin
			convSpeed <= wDataQ[SPEED_BIT];
			powerOn <= wDataQ[POWER_BIT];
			channel <= wDataQ[CHANNEL_MSB:0];
		end
	end

	// changing these mid-run does not restart; software drops one result
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			convSlow <= 1'b0;
			gainSel <= 1'b0;
		end else if (ampWrite) begin
			convSlow <= wDataQ[SLOW_BIT];
			gainSel <= wDataQ[GAIN_BIT];
		end
	end

	// --------------------------------------------------------------
	// conversion clock enable
	// --------------------------------------------------------------
	// free-running divider: a restart keeps the rate's phase, so the first
	// sample phase after it may be short by up to one conversion clock
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			divCount <= 2'h0;
		end else begin
			divCount <= divCount + 2'h1;
		end
	end

	always_comb begin
		if (convSlow) begin
			stepEnable = (divCount == QUARTER_LAST);
		end else if (convSpeed) begin
			stepEnable = 1'b1;
		end else begin
			stepEnable = divCount[0];
		end
	end

	// --------------------------------------------------------------
	// comparator synchroniser
	// --------------------------------------------------------------
	// the comparator output settles with no regard to the core clock
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			compMeta <= 1'b0;
			compSync <= 1'b0;
		end else begin
			compMeta <= compareHigh;
			compSync <= compMeta;
		end
	end

	// --------------------------------------------------------------
	// sequencer
	// --------------------------------------------------------------
	// the settle wait covers the synchroniser delay at full clock rate
	assign decideNow = (state == ST_CONVERT) && stepEnable && (settleCount == SETTLE_CYCLES);
	// comparator high keeps the trial bit; all-high ends at FFh, all-low at 00h
	assign decided = compSync ? sarCode : (sarCode & ~bitMask);
	// a conversion ending as halt begins is dropped: the converter is
	// already disabled, so nothing is stored and done stays as it was
	assign convDone = decideNow && bitMask[0] && !controlWrite && !haltMode;
	assign restartOn = controlWrite && wDataQ[POWER_BIT] && !haltMode;

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			state <= ST_OFF;
			stabCount <= '0;
			sampleCount <= '0;
			settleCount <= 2'h0;
			bitMask <= RESET_BYTE;
			sarCode <= RESET_BYTE;
		end else if (restartOn) begin
			state <= ST_SAMPLE;
			sampleCount <= '0;
		end else if (controlWrite || !powerOn || haltMode) begin
			state <= ST_OFF;
		end else begin
			unique case (state)
				ST_OFF: begin
					// only a halt exit arrives here with power still on
					state <= ST_STABLE;
					stabCount <= '0;
				end
				ST_STABLE: begin
					// counted on the core clock, whatever the conversion rate
					stabCount <= stabCount + 1'b1;
					if (stabCount == STAB_CYCLES - 1) begin
						state <= ST_SAMPLE;
						sampleCount <= '0;
					end
				end
				ST_SAMPLE: begin
					if (stepEnable) begin
						sampleCount <= sampleCount + 1'b1;
						if (sampleCount == SAMPLE_STEPS - 1) begin
							state <= ST_CONVERT;
							bitMask <= FIRST_TRIAL;
							sarCode <= FIRST_TRIAL;
							settleCount <= 2'h0;
						end
					end
				end
				ST_CONVERT: begin
					if (settleCount != SETTLE_CYCLES) begin
						settleCount <= settleCount + 2'h1;
					end
					if (decideNow) begin
						settleCount <= 2'h0;
						bitMask <= bitMask >> 1;
						if (bitMask[0]) begin
							sarCode <= decided;
							state <= ST_SAMPLE;
							sampleCount <= '0;
						end else begin
							sarCode <= decided | (bitMask >> 1);
						end
					end
				end
			endcase
		end
	end

	// --------------------------------------------------------------
	// result and done flag
	// --------------------------------------------------------------
	// an aborted conversion never reaches the result register
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			result <= RESET_BYTE;
		end else if (convDone) begin
			result <= decided;
		end
	end

	// clearing access wins so software never sees a flag for a value it
	// might have read stale; the next conversion sets it again
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			doneFlag <= 1'b0;
		end else if (controlWrite || resultRead) begin
			doneFlag <= 1'b0;
		end else if (convDone) begin
			doneFlag <= 1'b1;
		end
	end

	// --------------------------------------------------------------
	// analog side
	// --------------------------------------------------------------
	// amplifier rides on the converter power, so selecting it costs no wait
	assign converterPower = powerOn && !haltMode;
	assign inputSelect = channel;
	// gain of eight lives in the analog stage; clock limit is software's
	assign gainStageSelect = gainSel;
	assign sampleEnable = (state == ST_SAMPLE);
	assign holdActive = (state == ST_CONVERT);

endmodule : adc_sequencer_control

/* verilog/adc_seq_pkg.sv */
// constants, register map and types for the conversion sequencer
// Behaviour
// - input at top reference gives FFh, no overflow
// - input at bottom reference gives 00h
// - sample phase then eight approximation steps
// - powered on: conversions repeat back to back
// - power-on starts first conversion at once
// - each finished conversion sets done, no interrupt; one finishing in the cycle the result is read leaves done clear
// - result holds until next conversion finishes
// - control write while on aborts and restarts
// - result read or control write clears done
// - halt disables converter, then stabilisation wait
// - power bit switches converter and amplifier
// - channel field picks one of five inputs
// - reserved bits written zero, read zero
// - conversion clock: half, full or quarter rate
// - gain bit routes input through amplifier
// - registers at indices 34h, 35h, 36h, reset zero
// - amplifier multiplies input by eight
// - amplifier selection adds no start-up delay
package adc_seq_pkg;

	// --------------------------------------------------------------
	// register map: printed offsets are word indices
	// --------------------------------------------------------------
	localparam int ADDR_W = 8;
	localparam logic [5:0] IDX_CONTROL = 6'h34;
	localparam logic [5:0] IDX_RESULT = 6'h35;
	localparam logic [5:0] IDX_AMPLIFIER = 6'h36;
	localparam logic [ADDR_W-1:0] ADDR_CONTROL = {IDX_CONTROL, 2'b00};
	localparam logic [ADDR_W-1:0] ADDR_RESULT = {IDX_RESULT, 2'b00};
	localparam logic [ADDR_W-1:0] ADDR_AMPLIFIER = {IDX_AMPLIFIER, 2'b00};

	// --------------------------------------------------------------
	// field layout and reset values
	// --------------------------------------------------------------
	localparam int DONE_BIT = 7;
	localparam int SPEED_BIT = 6;
	localparam int POWER_BIT = 5;
	localparam int CHANNEL_MSB = 2;
	localparam int SLOW_BIT = 3;
	localparam int GAIN_BIT = 2;
	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam logic [2:0] RESET_CHANNEL = 3'h0;
	localparam logic [7:0] FULL_SCALE = 8'hFF;
	localparam logic [7:0] FIRST_TRIAL = 8'h80;
	localparam int GAIN_FACTOR = 8;

	// --------------------------------------------------------------
	// timing
	// --------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int STAB_TIME_NS = 1000;
	localparam int STAB_CYCLES = (STAB_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SAMPLE_STEPS = 4;
	localparam logic [1:0] SETTLE_CYCLES = 2'h3;
	localparam logic [1:0] QUARTER_LAST = 2'h3;

	// --------------------------------------------------------------
	// bus answers and sequencer states
	// --------------------------------------------------------------
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		ST_OFF,
		ST_STABLE,
		ST_SAMPLE,
		ST_CONVERT
	} seq_state_t;

endpackage : adc_seq_pkg

/* verification/adc_seq_sva.sv */
// concurrent checks on the sequencer's bus and phase ports
`timescale 1ns/10ps
module adc_seq_sva (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic haltMode,
	input wire logic converterPower,
	input wire logic sampleEnable,
	input wire logic holdActive
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	// ----------------------------------------
	// assertions
	// ----------------------------------------
	a_write_answer: assert property (s_axi_awvalid && s_axi_awready
		&& s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
		else $error("write answer late");
	a_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write answer dropped");
	a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read answer dropped");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer missing");
	a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
		else $error("upper read bits set");
	a_halt_power: assert property (haltMode |-> !converterPower)
		else $error("powered in halt");
	a_halt_phase: assert property (haltMode |=> !sampleEnable && !holdActive)
		else $error("phases run in halt");
	a_phase_order: assert property ($rose(holdActive) |-> $past(sampleEnable))
		else $error("hold without sample");
	a_phase_apart: assert property (!(sampleEnable && holdActive))
		else $error("sample and hold overlap");
	a_off_idle: assert property ($fell(converterPower) |=> !sampleEnable && !holdActive)
		else $error("phases run unpowered");
	c_hold: cover property ($rose(holdActive));
	c_slverr: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
	c_off: cover property ($fell(converterPower));
endmodule : adc_seq_sva

bind adc_sequencer_control adc_seq_sva chk (.*);

/* verification/analog_front_model.sv */
// comparator and input multiplexer model
`timescale 1ns/10ps
module analog_front_model (
	input wire logic core_clk,
	input wire logic [39:0] levels,
	input wire logic [2:0] inputSelect,
	input wire logic gainStageSelect,
	input wire logic converterPower,
	input wire logic [7:0] sarCode,
	output logic compareHigh
);
	logic [10:0] scaled;
	logic idleToggle = 1'b0;
	// an unpowered comparator gives no settled answer
	always_ff @(posedge core_clk) begin
		idleToggle <= !idleToggle;
	end
	always_comb begin
		scaled = {3'h0, levels[inputSelect*8 +: 8]};
		if (gainStageSelect) begin
			scaled = scaled * 11'h008;
		end
		compareHigh = converterPower ? (scaled >= {3'h0, sarCode}) : idleToggle;
	end
endmodule : analog_front_model

/* verification/testbench.sv */
// self-checking bench for the conversion sequencer
`timescale 1ns/10ps
module testbench;
	import adc_seq_pkg::*;
	logic core_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0, haltMode = 1'b0;
	logic s_axi_bready = 1'b1, s_axi_rready = 1'b1;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic compareHigh, converterPower, gainStageSelect, sampleEnable, holdActive;
	logic [1:0] s_axi_bresp, s_axi_rresp, rs;
	logic [2:0] inputSelect;
	logic [7:0] sarCode;
	// channel levels 4..0: C3, 11, 00, FF, 5A
	logic [39:0] levels = 40'hC31100FF5A;
	int errors = 0, comparisons = 0, cycles = 0;
	adc_sequencer_control dut (.*);
	analog_front_model front (.*);
	always #5 core_clk = ~core_clk;
	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic print_verdict();
		$display("errors=%0d comparisons=%0d", errors, comparisons);
		if (errors == 0 && comparisons > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : print_verdict
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 60000) begin
			errors++;
			print_verdict();
		end
	end
	task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			errors++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask : check
	// handshakes are judged at the falling edge, where pre-edge values are settled
	task automatic axiWrite(input logic [7:0] a, input logic [7:0] d);
		logic aw, w, b;
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h000000, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		b = 1'b0;
		while (!b) begin
			@(negedge core_clk);
			aw = s_axi_awvalid && s_axi_awready;
			w = s_axi_wvalid && s_axi_wready;
			b = s_axi_bvalid;
			rs = s_axi_bresp;
			@(posedge core_clk);
			if (aw) s_axi_awvalid <= 1'b0;
			if (w) s_axi_wvalid <= 1'b0;
		end
	endtask : axiWrite
	task automatic axiRead(input logic [7:0] a);
		logic ar, r;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		r = 1'b0;
		while (!r) begin
			@(negedge core_clk);
			ar = s_axi_arvalid && s_axi_arready;
			r = s_axi_rvalid;
			rd = s_axi_rdata;
			rs = s_axi_rresp;
			@(posedge core_clk);
			if (ar) s_axi_arvalid <= 1'b0;
		end
	endtask : axiRead
	task automatic waitDone();
		rd = 32'h0;
		for (int i = 0; i < 300 && !rd[DONE_BIT]; i++) axiRead(ADDR_CONTROL);
		check("done", 32'h1, {31'h0, rd[DONE_BIT]});
	endtask : waitDone
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic resetValues();
		for (int i = 0; i < 3; i++) begin
			axiRead(ADDR_CONTROL + 8'(4 * i));
			check("reset", 32'h0, rd);
		end
		axiWrite(8'hFC, 8'h00);
		check("bresp", 32'h2, {30'h0, rs});
		axiRead(8'h00);
		check("rresp", 32'h2, {30'h0, rs});
	endtask : resetValues
	task automatic convertAll();
		for (int i = 0; i < 5; i++) begin
			axiWrite(ADDR_CONTROL, 8'h60 | 8'(i));
			waitDone();
			axiRead(ADDR_RESULT);
			check("result", {24'h0, levels[8*i +: 8]}, rd);
			axiRead(ADDR_CONTROL);
			check("cleared", {24'h0, 8'h60 | 8'(i)}, rd);
		end
	endtask : convertAll
	task automatic gainPath();
		axiWrite(ADDR_AMPLIFIER, 8'hFF);
		axiRead(ADDR_AMPLIFIER);
		check("amplifier", 32'h0C, rd);
		check("gain pin", 32'h1, {31'h0, gainStageSelect});
		axiWrite(ADDR_CONTROL, 8'h23);
		check("no delay", 32'h1, {31'h0, sampleEnable});
		waitDone();
		axiRead(ADDR_RESULT);
		waitDone();
		axiRead(ADDR_RESULT);
		check("gained", 32'h88, rd);
	endtask : gainPath
	task automatic abortFlag();
		waitDone();
		axiWrite(ADDR_CONTROL, 8'h23);
		axiRead(ADDR_CONTROL);
		check("aborted", 32'h23, rd);
	endtask : abortFlag
	task automatic powerOff();
		logic [31:0] held;
		axiWrite(ADDR_CONTROL, 8'h03);
		check("power", 32'h0, {31'h0, converterPower});
		axiRead(ADDR_RESULT);
		held = rd;
		repeat (200) @(posedge core_clk);
		axiRead(ADDR_RESULT);
		check("held", held, rd);
		axiRead(ADDR_CONTROL);
		check("no done", 32'h03, rd);
	endtask : powerOff
	// steady-state sample phase: one conversion clock per sample step
	task automatic rateLength(input logic [7:0] amp, input logic [7:0] ctl, input int div);
		int n;
		n = 0;
		axiWrite(ADDR_AMPLIFIER, amp);
		axiWrite(ADDR_CONTROL, ctl);
		waitDone();
		@(negedge core_clk);
		while (sampleEnable) @(negedge core_clk);
		while (!sampleEnable) @(negedge core_clk);
		while (sampleEnable) begin
			n++;
			@(negedge core_clk);
		end
		@(posedge core_clk);
		check("sample length", 32'(SAMPLE_STEPS * div), 32'(n));
	endtask : rateLength
	task automatic rateSweep();
		rateLength(8'h00, 8'h60, 1);
		rateLength(8'h00, 8'h20, 2);
		rateLength(8'h08, 8'h60, 4);
	endtask : rateSweep
	task automatic haltStop();
		logic seen;
		axiWrite(ADDR_AMPLIFIER, 8'h00);
		axiWrite(ADDR_CONTROL, 8'h20);
		check("start", 32'h1, {31'h0, sampleEnable});
		haltMode <= 1'b1;
		repeat (3) @(posedge core_clk);
		check("halt power", 32'h0, {31'h0, converterPower});
		check("halt phase", 32'h0, {31'h0, sampleEnable | holdActive});
		haltMode <= 1'b0;
		seen = 1'b0;
		repeat (STAB_CYCLES) begin
			@(negedge core_clk);
			seen = seen | sampleEnable;
		end
		@(posedge core_clk);
		check("stabilise", 32'h0, {31'h0, seen});
		waitDone();
		axiRead(ADDR_RESULT);
		check("after halt", 32'h5A, rd);
	endtask : haltStop
	initial begin
		repeat (4) @(posedge core_clk);
		sys_rst <= 1'b0;
		@(posedge core_clk);
		resetValues();
		convertAll();
		rateSweep();
		gainPath();
		abortFlag();
		powerOff();
		haltStop();
		print_verdict();
	end
endmodule : testbench
